// File: rtl/iopr_defines.svh
`ifndef IOPR_DEFINES_SVH
`define IOPR_DEFINES_SVH

// Port geometry
`define IOPR_PINS 8
`define IOPR_NVM_WORDS 2
`define IOPR_NVM_AW 1

// Drive modes
`define IOPR_DM_HIZ_ANALOG 3'h0
`define IOPR_DM_HIZ_DIGITAL 3'h1
`define IOPR_DM_RES_PULLUP 3'h2
`define IOPR_DM_RES_PULLDN 3'h3
`define IOPR_DM_OD_LOW 3'h4
`define IOPR_DM_OD_HIGH 3'h5
`define IOPR_DM_STRONG 3'h6
`define IOPR_DM_RES_UPDN 3'h7

// Interrupt edge selections
`define IOPR_IRQ_OFF 2'h0
`define IOPR_IRQ_RISE 2'h1
`define IOPR_IRQ_FALL 2'h2
`define IOPR_IRQ_BOTH 2'h3

// Reset configuration words in nonvolatile storage
`define IOPR_NVM_ADDR_EN 1'h0
`define IOPR_NVM_ADDR_UP 1'h1
`define IOPR_PINS_ZERO 8'h00

`endif

// File: rtl/iopr_nvm.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopr_defines.svh"

module iopr_nvm (
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic [`IOPR_NVM_AW-1:0] rd_addr,
  output logic [`IOPR_PINS-1:0] rd_data,
  // Programming port
  input wire logic wr_en,
  input wire logic [`IOPR_NVM_AW-1:0] wr_addr,
  input wire logic [`IOPR_PINS-1:0] wr_data
);
  // Contents survive reset; only programming changes them
  logic [`IOPR_PINS-1:0] mem [`IOPR_NVM_WORDS];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

`default_nettype wire

// File: rtl/iopr_pkg.sv
package iopr_pkg;

  typedef logic [2:0] iopr_dmode_t;
  typedef logic [1:0] iopr_edge_t;

  // Per-port reset configuration loaded from nonvolatile storage
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] pull_up;
  } iopr_rcfg_t;

  // What the pad ring sees for each pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu_en;
    logic [7:0] pd_en;
    logic [7:0] ana_en;
    logic [7:0] in_en;
  } iopr_pad_t;

  typedef enum logic [1:0] {
    IOPR_RESET = 2'b00,
    IOPR_LOAD = 2'b01,
    IOPR_APPLY = 2'b11,
    IOPR_RUN = 2'b10
  } iopr_state_t;

endpackage

// File: rtl/iopr_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopr_defines.svh"

// How it works
// - Pins held high-Z analog during reset
// - After release, per-pin pull-up or pull-down on enabled pins
// - Copy nonvolatile reset config automatically at release
// - Low-power freezes pin state until changed, except in scan mode, where bsr_mode still drives the pins
// - Interrupt detect keeps running in low power
// - Open drain low drives only zeros
// - Every pin joins the boundary scan chain
// - Per-pin edge select sets status, raises request
module iopr_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Software configuration
  input wire logic [3*`IOPR_PINS-1:0] drive_mode,
  input wire logic [`IOPR_PINS-1:0] data_out,
  input wire logic [2*`IOPR_PINS-1:0] irq_edge,
  input wire logic [`IOPR_PINS-1:0] irq_clear,
  input wire logic low_power,
  // Nonvolatile programming
  input wire logic nvm_wr_en,
  input wire logic [`IOPR_NVM_AW-1:0] nvm_wr_addr,
  input wire logic [`IOPR_PINS-1:0] nvm_wr_data,
  // Boundary scan
  input wire logic bsr_mode,
  input wire logic bsr_shift,
  input wire logic bsr_capture,
  input wire logic bsr_update,
  input wire logic bsr_tdi,
  output logic bsr_tdo,
  // Pads
  input wire logic [`IOPR_PINS-1:0] pad_in,
  output iopr_pkg::iopr_pad_t pad,
  // Status
  output iopr_pkg::iopr_rcfg_t reset_cfg,
  output logic cfg_ready,
  output logic [`IOPR_PINS-1:0] irq_status,
  output logic irq_req,
  output logic wake
);
  import iopr_pkg::*;

  localparam int N = `IOPR_PINS;

  // ----------------------------------------
  // Reset configuration load
  // ----------------------------------------
  iopr_state_t state;
  logic [`IOPR_NVM_AW-1:0] nvm_addr;
  logic [N-1:0] nvm_data;

  iopr_nvm u_nvm (
    .sys_clk(sys_clk),
    .rd_addr(nvm_addr),
    .rd_data(nvm_data),
    .wr_en(nvm_wr_en),
    .wr_addr(nvm_wr_addr),
    .wr_data(nvm_wr_data)
  );

  // Read data lags address by one cycle, so the sequence walks both words
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= IOPR_RESET;
      nvm_addr <= `IOPR_NVM_ADDR_EN;
    end else begin
      case (state)
        IOPR_RESET: begin
          state <= IOPR_LOAD;
          nvm_addr <= `IOPR_NVM_ADDR_UP;
        end
        IOPR_LOAD: state <= IOPR_APPLY;
        IOPR_APPLY: state <= IOPR_RUN;
        default: state <= IOPR_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reset_cfg <= '0;
    end else if (state == IOPR_LOAD) begin
      reset_cfg.enable <= nvm_data;
    end else if (state == IOPR_APPLY) begin
      reset_cfg.pull_up <= nvm_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ready <= 1'b0;
    end else if (state == IOPR_APPLY) begin
      cfg_ready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Input synchroniser and edge detect
  // ----------------------------------------
  logic [N-1:0] pin_meta;
  logic [N-1:0] pin_sync;
  logic [N-1:0] pin_prev;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pad_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  function automatic logic edge_hit(input iopr_edge_t sel, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    case (sel)
      `IOPR_IRQ_RISE: edge_hit = rise;
      `IOPR_IRQ_FALL: edge_hit = fall;
      `IOPR_IRQ_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Live configuration and freeze
  // ----------------------------------------
  logic [3*N-1:0] mode_hold;
  logic [N-1:0] data_hold;

  // Low power freezes the drive registers; only a reset releases earlier
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_hold <= '0;
      data_hold <= '0;
    end else if (!low_power && cfg_ready) begin
      mode_hold <= drive_mode;
      data_hold <= data_out;
    end
  end

  // Software has taken over once any mode has been written nonzero
  logic sw_owned;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sw_owned <= 1'b0;
    end else if (cfg_ready && !low_power && |drive_mode) begin
      sw_owned <= 1'b1;
    end
  end

  // ----------------------------------------
  // Per-pin logic
  // ----------------------------------------
  logic [N-1:0] bsr_chain;
  logic [N-1:0] bsr_upd;
  logic [N-1:0] hit;
  iopr_pad_t next_pad;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_pin
      iopr_dmode_t m;
      logic d;
      assign m = mode_hold[3*g +: 3];
      assign d = data_hold[g];
      // Detection runs regardless of low power so an edge can wake;
      // gated until the copy ends, when both sync stages hold real pin levels
      assign hit[g] = cfg_ready & edge_hit(irq_edge[2*g +: 2], pin_sync[g], pin_prev[g]);

      always_comb begin
        next_pad.out[g] = 1'b0;
        next_pad.oe[g] = 1'b0;
        next_pad.pu_en[g] = 1'b0;
        next_pad.pd_en[g] = 1'b0;
        next_pad.ana_en[g] = 1'b1;
        next_pad.in_en[g] = 1'b0;
        // Scan waits for the copy too, so no pin leaves high-Z early
        if (!cfg_ready) begin
          next_pad.ana_en[g] = 1'b1;
        end else if (bsr_mode) begin
          next_pad.ana_en[g] = 1'b0;
          next_pad.oe[g] = 1'b1;
          next_pad.out[g] = bsr_upd[g];
        end else if (!sw_owned) begin
          if (reset_cfg.enable[g]) begin
            next_pad.ana_en[g] = 1'b0;
            next_pad.in_en[g] = 1'b1;
            next_pad.pu_en[g] = reset_cfg.pull_up[g];
            next_pad.pd_en[g] = ~reset_cfg.pull_up[g];
          end
        end else begin
          next_pad.ana_en[g] = (m == `IOPR_DM_HIZ_ANALOG);
          next_pad.in_en[g] = (m != `IOPR_DM_HIZ_ANALOG);
          case (m)
            `IOPR_DM_RES_PULLUP: begin
              next_pad.oe[g] = ~d;
              next_pad.pu_en[g] = d;
            end
            `IOPR_DM_RES_PULLDN: begin
              next_pad.oe[g] = d;
              next_pad.out[g] = d;
              next_pad.pd_en[g] = ~d;
            end
            `IOPR_DM_OD_LOW: begin
              next_pad.oe[g] = ~d;
            end
            `IOPR_DM_OD_HIGH: begin
              next_pad.oe[g] = d;
              next_pad.out[g] = d;
            end
            `IOPR_DM_STRONG: begin
              next_pad.oe[g] = 1'b1;
              next_pad.out[g] = d;
            end
            `IOPR_DM_RES_UPDN: begin
              next_pad.pu_en[g] = d;
              next_pad.pd_en[g] = ~d;
            end
            default: begin
            end
          endcase
        end
      end
    end
  endgenerate

  // Reset forces the analog high-Z value asynchronously
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad <= '{out: `IOPR_PINS_ZERO, oe: `IOPR_PINS_ZERO, pu_en: `IOPR_PINS_ZERO,
               pd_en: `IOPR_PINS_ZERO, ana_en: ~`IOPR_PINS_ZERO,
               in_en: `IOPR_PINS_ZERO};
    end else begin
      pad <= next_pad;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | hit;
    end
  end

  assign irq_req = |irq_status;
  assign wake = low_power & irq_req;

  // ----------------------------------------
  // Boundary scan cells
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_chain <= '0;
    end else if (bsr_capture) begin
      bsr_chain <= pin_sync;
    end else if (bsr_shift) begin
      bsr_chain <= {bsr_tdi, bsr_chain[N-1:1]};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_upd <= '0;
    end else if (bsr_update) begin
      bsr_upd <= bsr_chain;
    end
  end

  assign bsr_tdo = bsr_chain[0];
endmodule

`default_nettype wire

// File: tb/iopr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module iopr_pin_model (
  // Pad side
  input wire iopr_pkg::iopr_pad_t pad,
  // External drivers
  input wire logic [7:0] ext_drive,
  input wire logic [7:0] ext_val,
  // Pin levels
  output logic [7:0] pin
);
  import iopr_pkg::*;
  // Undriven pins float up to the board pull-up
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      pin[g] = pad.oe[g] ? pad.out[g] : (ext_drive[g] ? ext_val[g] : 1'h1);
    end
  end
endmodule
`default_nettype wire

// File: tb/iopr_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopr_defines.svh"
module iopr_port_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic low_power,
  input wire logic bsr_mode,
  input wire logic [`IOPR_PINS-1:0] irq_clear,
  input wire iopr_pkg::iopr_pad_t pad,
  input wire logic cfg_ready,
  input wire logic [`IOPR_PINS-1:0] irq_status,
  input wire logic irq_req,
  input wire logic wake
);
  import iopr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence load_seq;
    !cfg_ready [*3] ##1 cfg_ready;
  endsequence
  // Three cycles so a change already in the hold stage can land first
  sequence lp_seq;
    (low_power && !bsr_mode && cfg_ready) [*3];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  hiz_release_a: assert property ($rose(rstn) |-> pad.ana_en == 8'hFF && pad.oe == 8'h00)
    else $error("pads not analog high-Z at release");
  hiz_ready_a: assert property (!cfg_ready |-> pad.ana_en == 8'hFF && pad.oe == 8'h00)
    else $error("pads left high-Z before config copy");
  cfg_load_a: assert property ($rose(rstn) |-> load_seq)
    else $error("config copy latency wrong");
  cfg_sticky_a: assert property (cfg_ready |=> cfg_ready)
    else $error("cfg_ready dropped");
  irq_or_a: assert property (irq_req == |irq_status)
    else $error("irq_req not OR of status");
  wake_gate_a: assert property (wake == (low_power && irq_req))
    else $error("wake mismatch");
  status_hold_a: assert property ((~irq_status & $past(irq_status) & ~$past(irq_clear)) == 8'h00)
    else $error("status bit lost without clear");
  lp_freeze_a: assert property (lp_seq |-> $stable(pad))
    else $error("pad moved in low power");
endmodule
bind iopr_port iopr_port_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .low_power(low_power),
  .bsr_mode(bsr_mode), .irq_clear(irq_clear), .pad(pad), .cfg_ready(cfg_ready),
  .irq_status(irq_status), .irq_req(irq_req), .wake(wake));
`default_nettype wire

// File: tb/iopr_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module iopr_port_test;
  import iopr_pkg::*;
  logic sys_clk = 1'h0, rstn = 1'h0, low_power = 1'h0, nvm_wr_en = 1'h0, nvm_wr_addr = 1'h0;
  logic bsr_mode = 1'h0, bsr_shift = 1'h0, bsr_capture = 1'h0, bsr_update = 1'h0, bsr_tdi = 1'h0;
  logic [23:0] drive_mode = 24'h000000;
  logic [15:0] irq_edge = 16'h0000;
  logic [7:0] data_out = 8'h00, irq_clear = 8'h00, nvm_wr_data = 8'h00, pin, en, pu, d, p, q;
  logic [7:0] ext_drive = 8'hFF, ext_val = 8'h00, irq_status;
  logic bsr_tdo, cfg_ready, irq_req, wake;
  logic [31:0] seed = 32'hB4B3;
  iopr_pad_t pad, held;
  iopr_rcfg_t reset_cfg;
  int bad_count = 0, cmp_count = 0;
  iopr_port DUT (.sys_clk(sys_clk), .rstn(rstn), .drive_mode(drive_mode), .data_out(data_out),
    .irq_edge(irq_edge), .irq_clear(irq_clear), .low_power(low_power), .nvm_wr_en(nvm_wr_en),
    .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .bsr_mode(bsr_mode),
    .bsr_shift(bsr_shift), .bsr_capture(bsr_capture), .bsr_update(bsr_update),
    .bsr_tdi(bsr_tdi), .bsr_tdo(bsr_tdo), .pad_in(pin), .pad(pad), .reset_cfg(reset_cfg),
    .cfg_ready(cfg_ready), .irq_status(irq_status), .irq_req(irq_req), .wake(wake));
  iopr_pin_model u_pins (.pad(pad), .ext_drive(ext_drive), .ext_val(ext_val), .pin(pin));
  // ----------------------------------------
  // Helpers and reference model
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // Called at a rising edge: sees what the previous edge left settled
  task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic chk_cfg(input string name, input logic [47:0] e, input logic [47:0] g);
    chk(name, e, g);
  endtask
  task automatic chk_pad(input string name, input logic [47:0] e, input logic [47:0] g);
    chk(name, e, g);
  endtask
  task automatic chk_irq(input string name, input logic [47:0] e, input logic [47:0] g);
    chk(name, e, g);
  endtask
  task automatic chk_scan(input string name, input logic [47:0] e, input logic [47:0] g);
    chk(name, e, g);
  endtask
  function automatic logic [7:0] irq_exp(input logic [15:0] ed, input logic rise);
    for (int g = 0; g < 8; g++) irq_exp[g] = rise ? ed[2*g] : ed[2*g+1];
  endfunction
  task automatic test_done;
    $display("compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    tick(2000);
    bad_count++;
    $display("watchdog expired");
    test_done;
  end
  initial begin
    en = rnd();
    pu = rnd();
    nvm_wr_en <= 1'h1;
    nvm_wr_data <= en;
    tick(1);
    nvm_wr_addr <= 1'h1;
    nvm_wr_data <= pu;
    tick(1);
    nvm_wr_en <= 1'h0;
    rstn <= 1'h1;
    tick(5);
    chk_cfg("reset_cfg", {en, pu}, reset_cfg);
    chk_cfg("cfg_ready", 1'h1, cfg_ready);
    chk_pad("pu_en", {en & pu}, pad.pu_en);
    chk_pad("pd_en", {en & ~pu}, pad.pd_en);
    chk_pad("ana_en", {~en}, pad.ana_en);
    chk_pad("in_en", en, pad.in_en);
    $display("reset config test done");
    d = rnd();
    data_out <= d;
    drive_mode <= 24'h924924;
    // Let the board pull-up set the released level
    ext_drive <= 8'h00;
    tick(3);
    chk_pad("od oe", {~d}, pad.oe);
    chk_pad("od out", 8'h00, pad.out);
    chk_pad("od pin", d, pin);
    $display("open drain test done");
    drive_mode <= 24'h249249;
    ext_drive <= 8'hFF;
    // Pins settle before edge detection is armed
    tick(5);
    irq_edge <= 16'hE4E4;
    ext_val <= 8'hFF;
    tick(5);
    chk_irq("irq rise", irq_exp(irq_edge, 1'h1), irq_status);
    chk_irq("irq_req", 1'h1, irq_req);
    chk_irq("wake idle", 1'h0, wake);
    irq_clear <= 8'hFF;
    low_power <= 1'h1;
    tick(1);
    irq_clear <= 8'h00;
    drive_mode <= 24'hDB6DB6;
    tick(3);
    chk_irq("irq clear", 8'h00, irq_status);
    chk_irq("wake clear", 1'h0, wake);
    held = pad;
    ext_val <= 8'h00;
    tick(5);
    chk_irq("irq fall", irq_exp(irq_edge, 1'h0), irq_status);
    chk_irq("wake", 1'h1, wake);
    chk_pad("frozen pad", held, pad);
    chk_pad("frozen oe", 8'h00, pad.oe);
    $display("interrupt and low power test done");
    low_power <= 1'h0;
    drive_mode <= 24'h249249;
    p = rnd();
    q = rnd();
    ext_val <= p;
    tick(4);
    bsr_capture <= 1'h1;
    tick(1);
    bsr_capture <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      bsr_tdi <= q[i];
      bsr_shift <= 1'h1;
      tick(1);
      chk_scan("scan tdo", p[i], bsr_tdo);
    end
    bsr_shift <= 1'h0;
    bsr_update <= 1'h1;
    tick(1);
    bsr_update <= 1'h0;
    bsr_mode <= 1'h1;
    tick(3);
    chk_scan("scan out", q, pad.out);
    chk_scan("scan oe", 8'hFF, pad.oe);
    $display("boundary scan test done");
    // Mid-run reset with scan still selected and new stored config
    rstn <= 1'h0;
    drive_mode <= 24'h000000;
    en = rnd();
    pu = rnd();
    nvm_wr_en <= 1'h1;
    nvm_wr_addr <= 1'h0;
    nvm_wr_data <= en;
    tick(1);
    chk_pad("reset ana_en", 8'hFF, pad.ana_en);
    chk_pad("reset oe", 8'h00, pad.oe);
    nvm_wr_addr <= 1'h1;
    nvm_wr_data <= pu;
    tick(1);
    nvm_wr_en <= 1'h0;
    rstn <= 1'h1;
    tick(2);
    chk_pad("early ana_en", 8'hFF, pad.ana_en);
    chk_cfg("early cfg_ready", 1'h0, cfg_ready);
    bsr_mode <= 1'h0;
    tick(4);
    chk_cfg("reload cfg", {en, pu}, reset_cfg);
    chk_pad("reload pu_en", {en & pu}, pad.pu_en);
    chk_pad("reload pd_en", {en & ~pu}, pad.pd_en);
    chk_pad("reload ana_en", {~en}, pad.ana_en);
    chk_irq("no false edge", 8'h00, irq_status);
    $display("mid-run reset test done");
    test_done;
  end
endmodule
`default_nettype wire
